// ### test/interrupt_vector_placement_bench.sv
// Purpose: Self-checking bench for vector placement
// Assumes: Inputs change on the falling edge, fixed seed
// Notes:   Expected irq addresses come from exp_addr, reset addresses from do_reset
`timescale 1ns/1ps
module interrupt_vector_placement_bench;
    logic        clk;
    logic        rst_b;
    logic        fuse;
    logic [11:0] boot;
    logic [17:0] req;
    logic        gie;
    logic        ready;
    logic        wr;
    logic [1:0]  wdata;
    logic        done;
    logic        take;
    logic        rtake;
    logic [11:0] addr;
    logic [4:0]  num;
    logic        sel;
    logic        ce;
    logic        blk;
    logic [17:0] r;
    int          err_count;
    int          n_tests;
    int          seed;
    int          cnt;
    int          k;

    interrupt_vector_placement i_interrupt_vector_placement (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_boot_reset_select_fuse(fuse),
        .i_boot_start_addr(boot), .i_irq_req(req),
        .i_global_irq_enable(gie), .i_core_ready(ready), .i_ctrl_wr(wr),
        .i_ctrl_wdata(wdata), .i_instr_done(done), .o_vector_take(take),
        .o_reset_take(rtake), .o_vector_addr(addr), .o_vector_num(num),
        .o_vector_table_select(sel), .o_vector_change_enable(ce),
        .o_irq_blocked(blk));

    ivp_core_model i_ivp_core_model (
        .i_clk(clk), .i_rst_b(rst_b), .i_take(take),
        .o_ready(ready), .o_instr_done(done));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Lowest pending source wins
    function automatic logic [4:0] lowest(input logic [17:0] v);
        lowest = 5'h00;
        for (int j = 17; j >= 0; j--) if (v[j]) lowest = 5'(j);
    endfunction

    function automatic logic [11:0] exp_addr(input logic s,
            input logic [11:0] b, input logic [4:0] ix);
        exp_addr = (s ? b : 12'h000) + 12'(ix) + 12'h001;
    endfunction

    task check(input logic [11:0] seen, input logic [11:0] exp,
            input string msg);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg,
                seen, exp);
        end
    endtask

    task end_sim;
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait for the take pulse that rst_kind selects
    task wait_take(input logic rst_kind);
        cnt = 0;
        while ((rst_kind ? rtake : take) !== 1'b1 && cnt < 40) begin
            @(negedge clk);
            cnt++;
        end
    endtask

    task count_takes(input int n);
        cnt = 0;
        repeat (n) begin
            @(negedge clk);
            if (take === 1'b1) cnt++;
        end
    endtask

    task irq(input logic [17:0] v, input logic s);
        req = v;
        wait_take(1'b0);
        check(12'(take), 12'h001, "irq take");
        check(addr, exp_addr(s, boot, lowest(v)),
            "addr");
        check(12'(num), 12'(lowest(v)) + 12'h002, "num");
        req = 18'h0_0000;
        repeat (3) @(negedge clk);
    endtask

    task ctrl(input logic [1:0] d);
        @(negedge clk);
        wr = 1'b1;
        wdata = d;
        @(negedge clk);
        wr = 1'b0;
        wdata = 2'h0;
    endtask

    // Arm, then write the select with change enable cleared
    task move(input logic s);
        ctrl(2'h1);
        ctrl({s, 1'b0});
        check(12'(sel), 12'(s), "select");
        check(12'(ce), 12'h000, "enable clear");
        check(12'(blk), 12'h001, "blocked after move");
    endtask

    task do_reset(input logic f);
        @(negedge clk);
        fuse = f;
        rst_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        wait_take(1'b1);
        check(12'(rtake), 12'h001, "reset take");
        check(addr, f ? 12'h000 : boot, "reset addr");
        check(12'(num), 12'h001, "reset num");
        check(12'(sel), 12'h000, "select reset");
        @(negedge clk);
        check(12'(rtake), 12'h000, "reset pulse");
    endtask

    // Hang guard
    initial begin
        #(40 * 8000);
        err_count++;
        end_sim();
    end

    initial begin
        rst_b = 1'b0;
        fuse = 1'b1;
        boot = 12'h0C00;
        req = 18'h0_0000;
        gie = 1'b1;
        wr = 1'b0;
        wdata = 2'h0;
        err_count = 0;
        n_tests = 0;
        seed = 32'h2842_8805;
        do_reset(1'b1);
        count_takes(10);
        check(12'(cnt), 12'h000, "idle take");
        // Global enable off holds a request back
        gie = 1'b0;
        req = 18'h0_0001;
        count_takes(6);
        check(12'(cnt), 12'h000, "gie off take");
        gie = 1'b1;
        irq(18'h0_0001, 1'b0);
        for (k = 0; k < 18; k++) begin
            irq(18'h0_0001 << k, 1'b0);
        end
        for (k = 0; k < 16; k++) begin
            r = 18'($random(seed));
            if (r == 18'h0_0000) r = 18'h0_0001;
            irq(r, 1'b0);
        end
        // Arm without select write: four cycles, no take meanwhile
        ctrl(2'h1);
        check(12'(blk), 12'h001, "blocked on arm");
        req = 18'h0_0004;
        cnt = 0;
        for (k = 0; k < 5; k++) begin
            if (ce === 1'b1) cnt++;
            if (take === 1'b1) cnt += 100;
            @(negedge clk);
        end
        check(12'(cnt), 12'h004, "enable span");
        check(12'(blk), 12'h000, "block end");
        irq(18'h0_0004, 1'b0);
        move(1'b1);
        irq(18'h0_0002, 1'b1);
        // Select write without arming is ignored
        ctrl(2'h0);
        check(12'(sel), 12'h001, "unarmed write");
        for (k = 0; k < 6; k++) begin
            r = 18'($random(seed)) | 18'h2_0000;
            irq(r, 1'b1);
        end
        move(1'b0);
        irq(18'h2_0000, 1'b0);
        // Boot reset with a random boot start
        boot = 12'($random(seed)) & 12'h0F80;
        do_reset(1'b0);
        irq(18'h0_0010, 1'b0);
        move(1'b1);
        // Arming again right after a move reloads the change window
        ctrl(2'h1);
        check(12'(ce), 12'h001, "re-arm");
        ctrl(2'h2);
        irq(18'h0_0100, 1'b1);
        irq(18'h2_0000, 1'b1);
        end_sim();
    end
endmodule

// ### test/ivp_core_model.sv
// Purpose: Behavioural core fetch and sequencing partner
// Assumes: Same clock as placement logic, drives off the falling edge
// Notes:   Drops ready after every take, retires an instruction every 4
`timescale 1ns/1ps
module ivp_core_model (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_take,
    output logic      o_ready,
    output logic      o_instr_done
);
    logic [1:0] hold;
    logic [1:0] phase;

    // Ready low three cycles after a take, so takes never come back to back
    always @(negedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ready      <= 1'b1;
            o_instr_done <= 1'b0;
            hold         <= 2'h0;
            phase        <= 2'h0;
        end else begin
            phase        <= phase + 2'h1;
            o_instr_done <= (phase == 2'h0); // Slow retire, widens blocking
            if (i_take) begin
                o_ready <= 1'b0;
                hold    <= 2'h2;
            end else if (hold != 2'h0) begin
                hold <= hold - 2'h1;
            end else begin
                o_ready <= 1'b1;
            end
        end
    end
endmodule

// ### verilog/interrupt_vector_placement.sv
// Purpose: Reset and interrupt vector address generation for the core
// Assumes: Requests arrive enabled and pending from same-clock logic
// Notes:   Fuse and boot start address are pins, synchronised here
`timescale 1ns/1ps
// Contract
// RULE1: All reset causes share vector one
// RULE2: External irqs use offsets one and two
// RULE3: Timer vectors use offsets three to nine
// RULE4: Serial and ADC vectors use offsets A-E
// RULE5: Remaining vectors use offsets F to 12
// RULE6: Select set adds boot start to offsets
// RULE7: Programmed fuse starts at boot reset address
// RULE8: Placement follows all fuse/select combinations
// RULE9: Fuse one unprogrammed, zero programmed
// RULE10: Vector fetched only when source taken
// RULE11: Software arms change then writes select
// RULE12: Change enable clears after four cycles
// RULE13: Interrupts blocked during change sequence
// RULE14: Lowest vector number wins when several pending
module interrupt_vector_placement (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_boot_reset_select_fuse,
    input  wire logic [11:0] i_boot_start_addr,
    input  wire logic [17:0] i_irq_req,
    input  wire logic        i_global_irq_enable,
    input  wire logic        i_core_ready,
    input  wire logic        i_ctrl_wr,
    input  wire logic [1:0]  i_ctrl_wdata,
    input  wire logic        i_instr_done,
    output logic             o_vector_take,
    output logic             o_reset_take,
    output logic [11:0]      o_vector_addr,
    output logic [4:0]       o_vector_num,
    output logic             o_vector_table_select,
    output logic             o_vector_change_enable,
    output logic             o_irq_blocked
);
    logic                rst_meta;
    logic                rst_b;
    logic [12:0]         cfg_meta;
    logic [12:0]         cfg_q;
    logic                fuse_q;
    logic [11:0]         boot_q;
    logic [1:0]          settle_cnt;
    logic [1:0]          next_settle_cnt;
    logic                reset_pend;
    logic                next_reset_pend;
    logic                reset_fire;
    ivp_pkg::chg_state_t state;
    ivp_pkg::chg_state_t next_state;
    logic                next_sel;
    logic [2:0]          ce_cnt;
    logic [2:0]          next_ce_cnt;
    logic                ce_write;
    logic                irq_block_now;
    logic                irq_ok;
    logic                next_vector_take;
    logic                next_reset_take;
    logic [11:0]         next_vector_addr;
    logic [4:0]          next_vector_num;
    logic [11:0]         irq_base;

    ivp_pick_if pick_bus ();

    ivp_pick u_pick (
        .i_clk   (i_ref_clk),
        .i_rst_b (rst_b),
        .pick    (pick_bus.picker)
    );

    // Reset release through two flops, assertion stays asynchronous
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta <= 1'b0;
            rst_b    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b    <= rst_meta;
        end
    end

    // Fuse pins are static, so a plain two-flop sync is enough
    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_meta <= '0;
            cfg_q    <= '0;
        end else begin
            cfg_meta <= {i_boot_reset_select_fuse, i_boot_start_addr};
            cfg_q    <= cfg_meta;
        end
    end
    assign fuse_q = cfg_q[12];
    assign boot_q = cfg_q[11:0];

    // Hold the reset vector until the synced fuse is trustworthy
    always_comb begin
        next_settle_cnt = settle_cnt;
        next_reset_pend = reset_pend;
        reset_fire      = reset_pend && (settle_cnt == ivp_pkg::SYNC_SETTLE);
        if (reset_pend && !reset_fire) begin
            next_settle_cnt = settle_cnt + 2'h1;
        end
        if (reset_fire) begin
            next_reset_pend = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_cnt <= 2'h0;
            reset_pend <= 1'b1;
        end else begin
            settle_cnt <= next_settle_cnt;
            reset_pend <= next_reset_pend;
        end
    end

    // Timed change sequence for the table select
    assign ce_write = i_ctrl_wr && i_ctrl_wdata[ivp_pkg::CTRL_CE_BIT];
    always_comb begin
        next_state  = state;
        next_sel    = o_vector_table_select;
        next_ce_cnt = ce_cnt;
        unique case (state)
            ivp_pkg::CHG_IDLE: begin
                if (ce_write) begin                    // RULE11
                    next_state  = ivp_pkg::CHG_ARMED;
                    next_ce_cnt = ivp_pkg::CHANGE_CNT_LOAD;
                end
            end
            ivp_pkg::CHG_ARMED: begin
                if (ce_write) begin
                    next_ce_cnt = ivp_pkg::CHANGE_CNT_LOAD;
                end else if (i_ctrl_wr) begin
                    next_sel   = i_ctrl_wdata[ivp_pkg::CTRL_SEL_BIT];
                    next_state = ivp_pkg::CHG_HOLD;    // RULE12
                end else if (ce_cnt == 3'h0) begin
                    next_state = ivp_pkg::CHG_IDLE;    // RULE12
                end else begin
                    next_ce_cnt = ce_cnt - 3'h1;
                end
            end
            ivp_pkg::CHG_HOLD: begin
                // Blocked until the next instruction has completed
                if (ce_write) begin
                    next_state  = ivp_pkg::CHG_ARMED;
                    next_ce_cnt = ivp_pkg::CHANGE_CNT_LOAD;
                end else if (i_instr_done) begin
                    next_state = ivp_pkg::CHG_IDLE;    // RULE13
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state                 <= ivp_pkg::CHG_IDLE;
            o_vector_table_select <= 1'b0;
            ce_cnt                <= 3'h0;
        end else begin
            state                 <= next_state;
            o_vector_table_select <= next_sel;
            ce_cnt                <= next_ce_cnt;
        end
    end

    assign o_vector_change_enable = (state == ivp_pkg::CHG_ARMED);
    assign o_irq_blocked          = (state != ivp_pkg::CHG_IDLE);
    // Block from the arming write itself; I-bit is left alone
    assign irq_block_now = o_irq_blocked || ce_write;   // RULE13

    // Picker sees the raw requests; enable, ready and blocking gate only its result
    assign pick_bus.req = i_irq_req;
    assign irq_base = o_vector_table_select ? boot_q : ivp_pkg::APP_BASE;
    // Skip the cycle after a take so the core can drop ready
    assign irq_ok = pick_bus.valid && i_core_ready && i_global_irq_enable
                    && !irq_block_now && !reset_pend && !o_vector_take;

    // Vector address and number for the fetch side
    always_comb begin
        next_vector_take = irq_ok;                      // RULE10
        next_reset_take  = reset_fire;                  // RULE10
        next_vector_addr = o_vector_addr;
        next_vector_num  = o_vector_num;
        if (reset_fire) begin
            next_vector_num = ivp_pkg::VEC_NUM_RESET;   // RULE1
            if (fuse_q == ivp_pkg::FUSE_PROGRAMMED) begin  // RULE9
                next_vector_addr = boot_q;              // RULE7
            end else begin
                next_vector_addr = ivp_pkg::RESET_ADDR_APP; // RULE8
            end
        end else if (irq_ok) begin
            // RULE2 RULE3 RULE4 RULE5 RULE6
            next_vector_addr = irq_base
                               + ivp_pkg::VEC_OFFSET[pick_bus.idx];
            next_vector_num  = pick_bus.idx + ivp_pkg::VEC_NUM_FIRST_IRQ;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            o_vector_take <= 1'b0;
            o_reset_take  <= 1'b0;
            o_vector_addr <= ivp_pkg::RESET_ADDR_APP;
            o_vector_num  <= ivp_pkg::VEC_NUM_RESET;
        end else begin
            o_vector_take <= next_vector_take;
            o_reset_take  <= next_reset_take;
            o_vector_addr <= next_vector_addr;
            o_vector_num  <= next_vector_num;
        end
    end

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!rst_b);

    AST_RESET_ADDR: assert property (o_reset_take |->  // RULE1 RULE7 RULE9
        o_vector_num == ivp_pkg::VEC_NUM_RESET &&
        o_vector_addr == (($past(fuse_q) == ivp_pkg::FUSE_PROGRAMMED)
                          ? $past(boot_q) : ivp_pkg::RESET_ADDR_APP))
        else $error("reset vector address wrong");
    AST_EXT0_ADDR: assert property (o_vector_take &&  // RULE2 RULE6
        o_vector_num == ivp_pkg::VEC_NUM_FIRST_IRQ |->
        o_vector_addr == ($past(o_vector_table_select) ? $past(boot_q)
            : ivp_pkg::APP_BASE) + ivp_pkg::VEC_OFFSET[ivp_pkg::EXT0_IDX])
        else $error("external irq zero address wrong");
    AST_TIMER0_APP: assert property (o_vector_take &&  // RULE3 RULE8
        !$past(o_vector_table_select) && o_vector_num ==
        5'(ivp_pkg::TIMER0_IDX) + ivp_pkg::VEC_NUM_FIRST_IRQ |->
        o_vector_addr == ivp_pkg::VEC_OFFSET[ivp_pkg::TIMER0_IDX])
        else $error("timer0 overflow address wrong");
    AST_SPM_BOOT: assert property (o_vector_take &&  // RULE5 RULE8
        $past(o_vector_table_select) && o_vector_num ==
        5'(ivp_pkg::SPM_IDX) + ivp_pkg::VEC_NUM_FIRST_IRQ |->
        o_vector_addr == $past(boot_q) + ivp_pkg::VEC_OFFSET[ivp_pkg::SPM_IDX])
        else $error("store ready address in boot table wrong");
    AST_TAKE_CAUSE: assert property (o_vector_take |->  // RULE10
        $past(i_irq_req) != '0 && $past(i_global_irq_enable)
        && $past(i_core_ready))
        else $error("vector taken without a cause");
    AST_BLOCKED: assert property (irq_block_now |=> !o_vector_take)
        else $error("interrupt taken while blocked"); // RULE13
    AST_CE_TIMEOUT: assert property ($rose(o_vector_change_enable) ##0
        (!i_ctrl_wr)[*4] |=> !o_vector_change_enable)
        else $error("change enable outlived four cycles"); // RULE12
    AST_CE_SEL_WRITE: assert property (o_vector_change_enable && i_ctrl_wr
        && !i_ctrl_wdata[ivp_pkg::CTRL_CE_BIT] |=> !o_vector_change_enable
        && o_irq_blocked && o_vector_table_select ==
        $past(i_ctrl_wdata[ivp_pkg::CTRL_SEL_BIT]))
        else $error("select write mishandled"); // RULE12
    AST_SEL_GUARD: assert property (!o_vector_change_enable |=>
        $stable(o_vector_table_select))
        else $error("select changed without change enable"); // RULE11

    CVR_RESET: cover property (o_reset_take);
    CVR_BOOT_TABLE: cover property (o_vector_take && o_vector_table_select);
    CVR_MOVE: cover property (ce_write ##[1:4] (i_ctrl_wr && !ce_write)
        ##1 o_irq_blocked ##[1:8] !o_irq_blocked);
    CVR_TIMEOUT: cover property ($fell(o_vector_change_enable)
        && !o_irq_blocked);
endmodule

// ### verilog/ivp_pick.sv
// Purpose: Chooses the pending source with the lowest vector number
// Assumes: Clock and reset only serve the checks
// Notes:   Fixed priority, no fairness between sources
`timescale 1ns/1ps
module ivp_pick (
    input  wire logic  i_clk,
    input  wire logic  i_rst_b,
    ivp_pick_if.picker pick
);
    logic [17:0] lower_mask;

    // Scan downward so the lowest set bit is the last one kept
    always_comb begin
        pick.valid = 1'b0;
        pick.idx   = '0;
        for (int i = ivp_pkg::SRC_N - 1; i >= 0; i--) begin
            if (pick.req[i]) begin
                pick.valid = 1'b1;      // RULE14
                pick.idx   = 5'(i);     // RULE14
            end
        end
    end

    // Check helper: bits below the winner
    assign lower_mask = (18'h1_0000 >> 16 << pick.idx) - 18'h1;

    AST_PRIO_LOWEST: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        pick.valid |-> pick.req[pick.idx] && ((pick.req & lower_mask) == '0))
        else $error("picker did not choose lowest pending source"); // RULE14
    AST_PRIO_NONE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (pick.req != '0) |-> pick.valid)
        else $error("pending request not seen by picker"); // RULE14
    CVR_TWO_PENDING: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        pick.valid && ((pick.req & ~lower_mask) != (18'h1 << pick.idx)));
endmodule

// ### verilog/ivp_pick_if.sv
// Purpose: Carrier between placement logic and priority picker
// Assumes: Requests are already enabled and pending
// Notes:   Picker is combinational
`timescale 1ns/1ps
interface ivp_pick_if;
    logic [17:0] req;
    logic        valid;
    logic [4:0]  idx;

    modport picker (input req, output valid, output idx);
    modport user   (output req, input valid, input idx);
endinterface

// ### verilog/ivp_pkg.sv
// Purpose: Shared constants and types for interrupt vector placement
// Assumes: Program addresses are 12-bit flash word addresses
// Notes:   Offsets are indexed by interrupt source, lowest first
package ivp_pkg;
    // Widths
    localparam int ADDR_W = 12;
    localparam int SRC_N  = 18;
    localparam int NUM_W  = 5;

    // Reset placement
    localparam logic [11:0] RESET_ADDR_APP  = 12'h000;
    localparam logic [11:0] APP_BASE        = 12'h000;
    localparam logic        FUSE_PROGRAMMED = 1'b0;

    // Vector numbers
    localparam logic [4:0] VEC_NUM_RESET     = 5'h01;
    localparam logic [4:0] VEC_NUM_FIRST_IRQ = 5'h02;

    // Table offsets per source, index 0 is external_irq_zero
    localparam logic [11:0] VEC_OFFSET [SRC_N] = '{
        12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
        12'h007, 12'h008, 12'h009, 12'h00A, 12'h00B, 12'h00C,
        12'h00D, 12'h00E, 12'h00F, 12'h010, 12'h011, 12'h012};

    // Source indices used by checks
    localparam int EXT0_IDX   = 0;
    localparam int TIMER0_IDX = 8;
    localparam int SPM_IDX    = 17;

    // Control write fields
    localparam int CTRL_CE_BIT  = 0;
    localparam int CTRL_SEL_BIT = 1;

    // Timing counts in cycles
    localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;
    localparam logic [2:0] CHANGE_CNT_LOAD   = CHANGE_WINDOW_CYC - 3'h1;
    localparam logic [1:0] SYNC_SETTLE       = 2'h2;

    typedef enum logic [2:0] {
        CHG_IDLE  = 3'b001,
        CHG_ARMED = 3'b010,
        CHG_HOLD  = 3'b100
    } chg_state_t;
endpackage
